// >>> status_display_pkg.sv
// package: constants, codes and types for the service display encoder
package status_display_pkg;

    // bus register byte addresses
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] mode_addr = 8'h04;
    localparam logic [7:0] fault_addr = 8'h08;
    localparam logic [7:0] liquid_addr = 8'h0c;
    localparam logic [7:0] discharge_addr = 8'h10;
    localparam logic [7:0] fan_addr = 8'h14;
    localparam logic [7:0] starts_addr = 8'h18;
    localparam logic [7:0] runtime_addr = 8'h1c;
    localparam logic [7:0] check_addr = 8'h20;
    localparam logic [7:0] valve_addr = 8'h24;
    localparam logic [7:0] display_addr = 8'h28;

    // ctrl register fields
    localparam int run_bit = 0;
    localparam int trip_bit = 1;
    localparam int trip_clr_bit = 2;
    localparam int opmode_lsb = 4;
    localparam int relay_lsb = 8;

    // relay weights
    localparam logic [2:0] bypass_weight = 3'h1;
    localparam logic [2:0] reverse_weight = 3'h2;
    localparam logic [2:0] comp_weight = 3'h4;

    // timing
    localparam int clk_mhz = 250;
    localparam int tick_ms = 1000;
    localparam int tick_cycles = clk_mhz * 1000 * tick_ms;

    // temperature range
    localparam logic signed [7:0] liquid_min = -8'sd39;
    localparam logic signed [7:0] liquid_max = 8'sd88;

    // glyph codes (index into segment table)
    localparam logic [4:0] g_0 = 5'h00;
    localparam logic [4:0] g_1 = 5'h01;
    localparam logic [4:0] g_a = 5'h0a;
    localparam logic [4:0] g_b = 5'h0b;
    localparam logic [4:0] g_c = 5'h0c;
    localparam logic [4:0] g_d = 5'h0d;
    localparam logic [4:0] g_e = 5'h0e;
    localparam logic [4:0] g_f = 5'h0f;
    localparam logic [4:0] g_h = 5'h10;
    localparam logic [4:0] g_u = 5'h11;
    localparam logic [4:0] g_l = 5'h12;
    localparam logic [4:0] g_minus = 5'h13;
    localparam logic [4:0] g_blank = 5'h14;

    typedef enum logic [1:0] {op_stop, op_cool, op_heat, op_defrost} opmode_t;

    // fault sources; code number in the low bits picks a check code
    typedef enum logic [3:0] {
        flt_none, flt_rx, flt_tx, flt_wire_a, flt_wire_b, flt_input,
        flt_dis_temp, flt_dis_sensor, flt_liq_sensor, flt_overcur,
        flt_high_p, flt_low_p
    } fault_t;

    typedef struct packed {
        logic [6:0] tens;
        logic [6:0] units;
    } seg_pair_t;

    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [7:0] haddr;
    } ahb_addr_t;

endpackage : status_display_pkg

// >>> service_status_display_encoder.sv
// service display encoder: status registers over AHB-Lite, two seven-segment digits out
// Behaviour
// - selector at 0 without trip: steady display of operation mode and relays
// - tens digit: 0 stopped, C cooling or dry, H heating, d defrost
// - units digit is relay weight sum: bypass 1, reversing 2, compressor 4
// - after protective stop blink check code; at selector 0 side digit 0 outdoor, 1 indoor replaces the code digit
// - power-on faults show E8, E9, EA, Eb and F8
// - running faults show U2, U3, U4, U6, UE and UL
// - selector switch picks the displayed item as code or number
// - liquid temperature -39..88, minus alternates with magnitude each second
// - values 100 or more alternate hundreds digit with last two digits
// - check-mode items light one segment per active abnormality flag
// - setting jumper drives the setting_mode output and display register bit 16, accepted only while stopped
`timescale 1ns/10ps
module service_status_display_encoder
    import status_display_pkg::*;
#(
    parameter int tick_len = tick_cycles
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // switches and jumper pins
    input wire logic [5:0] monitor_select_switch,
    input wire logic setting_mode_jumper,
    // display
    output seg_pair_t service_display,
    output logic setting_mode
);

    // segment map, bit order gfedcba
    function automatic logic [6:0] glyph(input logic [4:0] g);
        unique case (g)
            5'h00: glyph = 7'h3f;
            5'h01: glyph = 7'h06;
            5'h02: glyph = 7'h5b;
            5'h03: glyph = 7'h4f;
            5'h04: glyph = 7'h66;
            5'h05: glyph = 7'h6d;
            5'h06: glyph = 7'h7d;
            5'h07: glyph = 7'h07;
            5'h08: glyph = 7'h7f;
            5'h09: glyph = 7'h6f;
            5'h0a: glyph = 7'h77;
            5'h0b: glyph = 7'h7c;
            5'h0c: glyph = 7'h39;
            5'h0d: glyph = 7'h5e;
            5'h0e: glyph = 7'h79;
            5'h0f: glyph = 7'h71;
            5'h10: glyph = 7'h76;
            5'h11: glyph = 7'h3e;
            5'h12: glyph = 7'h38;
            5'h13: glyph = 7'h40;
            default: glyph = 7'h00;
        endcase
    endfunction : glyph

    // number 0..999 to two digits, alternating phase picks hundreds or last two
    function automatic seg_pair_t number(input logic [9:0] v, input logic phase);
        logic [9:0] hund;
        logic [9:0] rest;
        logic [9:0] tens;
        hund = v / 10'd100;
        rest = v % 10'd100;
        tens = rest / 10'd10;
        if (v >= 10'd100 && !phase) begin
            number.tens = glyph(hund[4:0]);
            number.units = glyph(g_blank);
        end else begin
            number.tens = glyph(tens[4:0]);
            number.units = glyph(5'(rest % 10'd10));
        end
    endfunction : number

    // synchronisers for pins
    logic [5:0] sw_s1_ff, sw_s2_ff;
    logic jmp_s1_ff, jmp_s2_ff;

    // registers
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [3:0] fault_ff, nxt_fault;
    logic fault_indoor_ff, nxt_fault_indoor;
    logic [7:0] liquid_ff, nxt_liquid;
    logic [7:0] discharge_ff, nxt_discharge;
    logic [9:0] fan_ff, nxt_fan;
    logic [9:0] starts_ff, nxt_starts;
    logic [9:0] runtime_ff, nxt_runtime;
    logic [15:0] check_ff, nxt_check;
    logic [9:0] valve_ff, nxt_valve;
    logic setmode_ff, nxt_setmode;

    // bus phase
    ahb_addr_t ap_ff, nxt_ap;
    logic ap_valid_ff, nxt_ap_valid;
    logic [31:0] rdata_ff, nxt_rdata;

    // tick and display
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic phase_ff, nxt_phase;
    seg_pair_t disp_ff, nxt_disp;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_s1_ff <= 6'h00;
            sw_s2_ff <= 6'h00;
            jmp_s1_ff <= 1'b0;
            jmp_s2_ff <= 1'b0;
        end else begin
            sw_s1_ff <= monitor_select_switch;
            sw_s2_ff <= sw_s1_ff;
            jmp_s1_ff <= setting_mode_jumper;
            jmp_s2_ff <= jmp_s1_ff;
        end
    end

    logic wr_en;
    logic running;
    opmode_t opmode;
    logic [2:0] relays;
    assign wr_en = ap_valid_ff && ap_ff.hwrite;
    assign running = ctrl_ff[run_bit];
    assign opmode = opmode_t'(ctrl_ff[opmode_lsb +: 2]);
    assign relays = ctrl_ff[relay_lsb +: 3];

    // bus and register next values; no wait states
    always_comb begin
        nxt_ap = '{htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr[7:0]};
        nxt_ap_valid = hsel && hready && htrans[1];
        nxt_ctrl = ctrl_ff;
        nxt_fault = fault_ff;
        nxt_fault_indoor = fault_indoor_ff;
        nxt_liquid = liquid_ff;
        nxt_discharge = discharge_ff;
        nxt_fan = fan_ff;
        nxt_starts = starts_ff;
        nxt_runtime = runtime_ff;
        nxt_check = check_ff;
        nxt_valve = valve_ff;
        nxt_rdata = 32'h0000_0000;
        if (wr_en) begin
            unique case (ap_ff.haddr)
                ctrl_addr: nxt_ctrl = {20'h00000, 1'b0, hwdata[10:8], 2'h0, hwdata[5:4],
                                       2'h0, hwdata[1:0]};
                fault_addr: begin
                    nxt_fault = hwdata[3:0];
                    nxt_fault_indoor = hwdata[4];
                end
                liquid_addr: begin
                    // clamp to displayable range
                    if ($signed(hwdata[7:0]) < liquid_min) nxt_liquid = liquid_min;
                    else if ($signed(hwdata[7:0]) > liquid_max) nxt_liquid = liquid_max;
                    else nxt_liquid = hwdata[7:0];
                end
                discharge_addr: nxt_discharge = hwdata[7:0];
                fan_addr: nxt_fan = hwdata[9:0];
                starts_addr: nxt_starts = hwdata[9:0];
                runtime_addr: nxt_runtime = hwdata[9:0];
                check_addr: nxt_check = hwdata[15:0];
                valve_addr: nxt_valve = hwdata[9:0];
                default: ;
            endcase
            // write-one to trip_clr drops the protective stop
            if (ap_ff.haddr == ctrl_addr && hwdata[trip_clr_bit]) nxt_ctrl[trip_bit] = 1'b0;
        end
        if (nxt_ap_valid && !hwrite) begin
            unique case (haddr[7:0])
                ctrl_addr: nxt_rdata = ctrl_ff;
                mode_addr: nxt_rdata = {26'h0, sw_s2_ff};
                fault_addr: nxt_rdata = {27'h0, fault_indoor_ff, fault_ff};
                liquid_addr: nxt_rdata = {24'h0, liquid_ff};
                discharge_addr: nxt_rdata = {24'h0, discharge_ff};
                fan_addr: nxt_rdata = {22'h0, fan_ff};
                starts_addr: nxt_rdata = {22'h0, starts_ff};
                runtime_addr: nxt_rdata = {22'h0, runtime_ff};
                check_addr: nxt_rdata = {16'h0, check_ff};
                valve_addr: nxt_rdata = {22'h0, valve_ff};
                display_addr: nxt_rdata = {15'h0, setmode_ff, 2'h0, disp_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        // jumper level only taken over while the unit is stopped
        nxt_setmode = (!running) ? jmp_s2_ff : setmode_ff;
    end

    // check code glyphs of the current fault
    function automatic seg_pair_t check_code(input logic [3:0] f);
        unique case (fault_t'(f))
            flt_rx: check_code = '{glyph(g_e), glyph(5'h08)};
            flt_tx: check_code = '{glyph(g_e), glyph(5'h09)};
            flt_wire_a: check_code = '{glyph(g_e), glyph(g_a)};
            flt_wire_b: check_code = '{glyph(g_e), glyph(g_b)};
            flt_input: check_code = '{glyph(g_f), glyph(5'h08)};
            flt_dis_temp: check_code = '{glyph(g_u), glyph(5'h02)};
            flt_dis_sensor: check_code = '{glyph(g_u), glyph(5'h03)};
            flt_liq_sensor: check_code = '{glyph(g_u), glyph(5'h04)};
            flt_overcur: check_code = '{glyph(g_u), glyph(5'h06)};
            flt_high_p: check_code = '{glyph(g_u), glyph(g_e)};
            flt_low_p: check_code = '{glyph(g_u), glyph(g_l)};
            default: check_code = '{glyph(g_0), glyph(g_0)};
        endcase
    endfunction : check_code

    // display contents, recomputed once per tick
    logic tick;
    seg_pair_t normal_view, item_view, trip_view;
    logic [7:0] liq_mag;
    always_comb begin
        tick = (tick_cnt_ff == 32'(tick_len - 1));
        nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
        nxt_phase = tick ? !phase_ff : phase_ff;
        unique case (opmode)
            op_stop: normal_view.tens = glyph(g_0);
            op_cool: normal_view.tens = glyph(g_c);
            op_heat: normal_view.tens = glyph(g_h);
            op_defrost: normal_view.tens = glyph(g_d);
        endcase
        // relay bits: [0] bypass, [1] reversing, [2] compressor
        normal_view.units = glyph({2'h0, (relays[0] ? bypass_weight : 3'h0)
                                       | (relays[1] ? reverse_weight : 3'h0)
                                       | (relays[2] ? comp_weight : 3'h0)});
        liq_mag = liquid_ff[7] ? 8'(-liquid_ff) : liquid_ff;
        // held in a variable: a member cannot be picked straight off a call
        trip_view = check_code(fault_ff);
        unique case (sw_s2_ff)
            6'h00: item_view = check_code(fault_ff);
            6'h01: begin
                if (!liquid_ff[7] && liquid_ff != 8'h00) item_view = number({2'h0, liq_mag}, 1'b1);
                else if (!phase_ff) item_view = '{glyph(g_minus), glyph(g_blank)};
                else item_view = number({2'h0, liq_mag}, 1'b1);
            end
            6'h02: item_view = number({2'h0, discharge_ff}, phase_ff);
            6'h03: item_view = number(fan_ff, phase_ff);
            6'h04: item_view = number(starts_ff, phase_ff);
            6'h05: item_view = number(runtime_ff, phase_ff);
            6'h06: item_view = '{check_ff[6:0], 7'h00};
            6'h07: item_view = '{check_ff[14:8], 7'h00};
            6'h08: item_view = number(valve_ff, phase_ff);
            default: item_view = normal_view;
        endcase
        nxt_disp = disp_ff;
        if (tick) begin
            if (ctrl_ff[trip_bit]) begin
                // blink: check code on one second, dark the next
                if (phase_ff) nxt_disp = '{glyph(g_blank), glyph(g_blank)};
                else if (sw_s2_ff == 6'h00)
                    nxt_disp = '{trip_view.tens,
                                 glyph(fault_indoor_ff ? g_1 : g_0)};
                else nxt_disp = trip_view;
            end else if (sw_s2_ff == 6'h00) nxt_disp = normal_view;
            else nxt_disp = item_view;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= 32'h0000_0000;
            fault_ff <= 4'h0;
            fault_indoor_ff <= 1'b0;
            liquid_ff <= 8'h00;
            discharge_ff <= 8'h00;
            fan_ff <= 10'h000;
            starts_ff <= 10'h000;
            runtime_ff <= 10'h000;
            check_ff <= 16'h0000;
            valve_ff <= 10'h000;
            setmode_ff <= 1'b0;
            ap_ff <= '0;
            ap_valid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            tick_cnt_ff <= 32'h0000_0000;
            phase_ff <= 1'b0;
            disp_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            fault_ff <= nxt_fault;
            fault_indoor_ff <= nxt_fault_indoor;
            liquid_ff <= nxt_liquid;
            discharge_ff <= nxt_discharge;
            fan_ff <= nxt_fan;
            starts_ff <= nxt_starts;
            runtime_ff <= nxt_runtime;
            check_ff <= nxt_check;
            valve_ff <= nxt_valve;
            setmode_ff <= nxt_setmode;
            ap_ff <= nxt_ap;
            ap_valid_ff <= nxt_ap_valid;
            rdata_ff <= nxt_rdata;
            tick_cnt_ff <= nxt_tick_cnt;
            phase_ff <= nxt_phase;
            disp_ff <= nxt_disp;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign service_display = disp_ff;
    assign setting_mode = setmode_ff;

endmodule : service_status_display_encoder

// >>> tech_model.sv
// technician model: sets selector and jumper pins like a person would
`timescale 1ns/10ps
module tech_model (
    // clock
    input wire logic hclk,
    // requests from the bench
    input wire logic [5:0] sel_req,
    input wire logic jumper_req,
    // pins toward the block
    output logic [5:0] monitor_select_switch,
    output logic setting_mode_jumper
);
    // pins move a clock after the request, on the same hclk edge as the bus
    always_ff @(posedge hclk) begin
        monitor_select_switch <= sel_req;
        setting_mode_jumper <= jumper_req;
    end
endmodule : tech_model

// >>> service_status_display_encoder_sva.sv
// checker: port-level properties of the service display encoder
`timescale 1ns/10ps
module display_checker
    import status_display_pkg::*;
#(
    parameter int tick_len = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // pins
    input wire logic setting_mode_jumper,
    input wire seg_pair_t service_display,
    input wire logic setting_mode
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [31:0] gap_ff;
    logic [31:0] nxt_gap;
    logic rd;
    assign rd = hsel && hready && htrans[1] && !hwrite;
    // counts cycles since the display last moved; saturates to stay small
    always_comb begin
        nxt_gap = (gap_ff < 32'h3ff) ? gap_ff + 32'h1 : gap_ff;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff <= tick_len;
        end else begin
            gap_ff <= (service_display != $past(service_display)) ? 32'h0 : nxt_gap;
        end
    end
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_hrdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0)
        else $error("read data outside a data phase");
    a_read_display: assert property (rd && haddr[7:0] == display_addr |=>
        hrdata[13:0] == $past(service_display) && hrdata[31:17] == 15'h0)
        else $error("display read does not match display");
    a_refresh_spacing: assert property ($changed(service_display) |->
        gap_ff >= tick_len - 1)
        else $error("display moved between ticks");
    a_setting_rise: assert property ($rose(setting_mode) |->
        $past(setting_mode_jumper, 2) || $past(setting_mode_jumper, 3))
        else $error("setting mode set without jumper");
    a_setting_fall: assert property ($fell(setting_mode) |->
        !$past(setting_mode_jumper, 2) || !$past(setting_mode_jumper, 3))
        else $error("setting mode left with jumper shorted");
    a_minus_blank: assert property (service_display.tens == 7'h40 |->
        service_display.units == 7'h00)
        else $error("minus not paired with blank");
    a_setting_stable: assert property (setting_mode_jumper == setting_mode [*8] |=>
        setting_mode == $past(setting_mode))
        else $error("setting mode moved on its own");
    c_blink_dark: cover property (service_display == 14'h0);
    c_minus: cover property (service_display.tens == 7'h40);
    c_setting: cover property ($rose(setting_mode));
endmodule : display_checker

// >>> test_service_status_display_encoder.sv
// testbench: bus stimulus, display decoding checks and final verdict
`timescale 1ns/10ps
`define chk(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_service_status_display_encoder;
    import status_display_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, jumper_req = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [5:0] sel_req = 0, msel;
    logic jmp, hreadyout, hresp, setting_mode;
    logic [31:0] hrdata;
    seg_pair_t service_display;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    logic [6:0] dig [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f};
    logic [6:0] mode_seg [4] = '{7'h3f, 7'h39, 7'h76, 7'h5e};
    always #2 hclk = ~hclk;
    service_status_display_encoder #(.tick_len(8)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .monitor_select_switch(msel), .setting_mode_jumper(jmp),
        .service_display(service_display), .setting_mode(setting_mode));
    tech_model tech (.hclk(hclk), .sel_req(sel_req), .jumper_req(jumper_req),
        .monitor_select_switch(msel), .setting_mode_jumper(jmp));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hsel <= 0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // phase of the eight-cycle alternation is unknown, so poll for each view
    task automatic see(input logic [13:0] e, input logic [13:0] m);
        int i;
        for (i = 0; i < 64 && ((service_display & m) !== e); i++) @(posedge hclk);
        `chk(service_display & m, e)
    endtask : see
    task automatic t_reset();
        `chk(service_display, 14'h0)
        `chk(setting_mode, 1'b0)
        bus(0, 8'h30, 0);
        `chk(rd, 32'h0)
        $display("test reset done");
    endtask : t_reset
    task automatic t_normal();
        int i;
        for (i = 0; i < 8; i++) begin
            bus(1, ctrl_addr, 32'h1 | ((i % 4) << opmode_lsb) | (i << relay_lsb));
            see({mode_seg[i % 4], dig[i]}, 14'h3fff);
            repeat (20) @(posedge hclk);
            `chk(service_display, {mode_seg[i % 4], dig[i]})
        end
        $display("test normal done");
    endtask : t_normal
    task automatic t_trip(input logic [4:0] f, input logic [6:0] t, input logic [6:0] u);
        bus(1, fault_addr, {27'h0, f});
        bus(1, ctrl_addr, 32'h2);
        see({t, dig[f[4]]}, 14'h3fff);
        see(14'h0, 14'h3fff);
        sel_req <= 6'h3;
        see({t, u}, 14'h3fff);
        sel_req <= 6'h0;
        bus(1, ctrl_addr, 32'h4);
        $display("test trip done");
    endtask : t_trip
    // one selector item: both alternation views must appear in turn
    task automatic two_views(input logic [5:0] s, input logic [7:0] a, input logic [31:0] d,
        input logic [13:0] e0, input logic [13:0] e1);
        sel_req <= s;
        bus(1, a, d);
        see(e0, 14'h3fff);
        see(e1, 14'h3fff);
    endtask : two_views
    task automatic t_values();
        sel_req <= 6'h1;
        bus(1, liquid_addr, 32'hf1);
        see({7'h40, 7'h00}, 14'h3fff);
        see({dig[1], dig[5]}, 14'h3fff);
        bus(0, mode_addr, 0);
        `chk(rd[5:0], 6'h1)
        sel_req <= 6'h2;
        bus(1, discharge_addr, 32'hd8);
        see({dig[2], 7'h00}, 14'h3fff);
        see({dig[1], dig[6]}, 14'h3fff);
        sel_req <= 6'h6;
        bus(1, check_addr, 32'h55);
        see({7'h55, 7'h00}, 14'h3f80);
        sel_req <= 6'h7;
        bus(1, check_addr, 32'h2a00);
        see({7'h2a, 7'h00}, 14'h3fff);
        // values chosen so that no view of one item matches a view of the item before
        two_views(6'h3, fan_addr, 32'h64, {dig[1], 7'h00}, {dig[0], dig[0]});
        two_views(6'h4, starts_addr, 32'h1a9, {dig[4], 7'h00}, {dig[2], dig[5]});
        two_views(6'h8, valve_addr, 32'hc8, {dig[2], 7'h00}, {dig[0], dig[0]});
        two_views(6'h5, runtime_addr, 32'h159, {dig[3], 7'h00}, {dig[4], dig[5]});
        two_views(6'h1, liquid_addr, 32'hc0, {7'h40, 7'h00}, {dig[3], dig[9]});
        two_views(6'h1, liquid_addr, 32'h7f, {dig[8], dig[8]}, {dig[8], dig[8]});
        sel_req <= 6'h0;
        $display("test values done");
    endtask : t_values
    task automatic t_setting();
        bus(1, ctrl_addr, 32'h1);
        jumper_req <= 1;
        repeat (10) @(posedge hclk);
        `chk(setting_mode, 1'b0)
        bus(1, ctrl_addr, 32'h0);
        repeat (10) @(posedge hclk);
        `chk(setting_mode, 1'b1)
        bus(0, display_addr, 0);
        `chk(rd[16], 1'b1)
        jumper_req <= 0;
        repeat (10) @(posedge hclk);
        `chk(setting_mode, 1'b0)
        $display("test setting done");
    endtask : t_setting
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_reset();
        t_normal();
        t_trip(5'h01, 7'h79, 7'h7f);
        t_trip(5'h15, 7'h71, 7'h7f);
        t_trip(5'h0b, 7'h3e, 7'h38);
        t_values();
        t_setting();
        tally_and_finish();
    end
endmodule : test_service_status_display_encoder
bind service_status_display_encoder display_checker #(.tick_len(tick_len)) chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .setting_mode_jumper(setting_mode_jumper),
    .service_display(service_display), .setting_mode(setting_mode));
